// [logic/updown_counter_regs.vh]
// Purpose: named constants for the BCD up/down counter with compare
// Assumes: 20 MHz ref_clk, classic Wishbone slave with 32-bit data
// Notes: offsets are byte addresses of aligned words
`ifndef UPDOWN_COUNTER_REGS_VH
`define UPDOWN_COUNTER_REGS_VH

// ****************************************************
// Register map
// ****************************************************
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_COUNT 4'h8
`define OFS_REG 4'hC
`define OFS_IRQ_STAT 4'h0
`define OFS_IRQ_MASK 4'h4

// ****************************************************
// Control register fields
// ****************************************************
`define CTRL_CC_VARIANT 0
`define CTRL_DECADE 1
`define CTRL_WIDTH 2
`define CTRL_RESET_VAL 2'h0

// ****************************************************
// Interrupt events
// ****************************************************
`define EV_EQUAL 0
`define EV_ZERO 1
`define EV_LOAD_DONE 2
`define EV_CARRY 3
`define EV_WIDTH 4

// ****************************************************
// Three-level pin codes
// ****************************************************
`define TRI_OPEN 2'h0
`define TRI_HIGH 2'h1
`define TRI_LOW 2'h2

// ****************************************************
// Timing
// ****************************************************
`define CLK_HZ 20000000
`define SCAN_HZ 2500
`define SCAN_DIV (`CLK_HZ / `SCAN_HZ)
`define LOAD_MAX_US 5000
`define LOAD_MAX_CYC ((`CLK_HZ / 1000000) * `LOAD_MAX_US)

`endif

// [logic/bcd_updown_counter_compare.v]
// Purpose: four-decade BCD up/down counter with compare register and preset port
// Assumes: all pins synchronous to ref_clk; three-level pins arrive pre-decoded
// Notes: registers on classic Wishbone; one interrupt from sticky event bits
//
// Contract
// - Common-cathode variant reads BCD port inputs active low, outputs stay active high.
// - Preset load finishes within 5ms after the preset control is released.
// - Equality and zero flags are not valid while a preset load runs.
// - Flags come from a combinational compare and may glitch during loads.
// - Counter and register presets raised together load the same BCD value.
// - A reload lasts four digit periods; count edges in it may be lost.
// - Register holds until next register preset; reset clears the counter and zeros any register digits preset while it is low.
// - Preset, off and view controls each decode high, low and open distinctly.
// - Counter preset held low keeps the BCD output drivers disabled.
// - Undriven BCD inputs read as 0000.
// - Count rising edge increments when up, decrements when down, inhibited in reset/preset.
// - Reset low clears the counter; store low copies counter to output latches.
// - Preset restarts scan at the top digit, loads each digit, repeats while requested.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "updown_counter_regs.vh"

module bcd_updown_counter_compare #(
  parameter SCAN_DIV = `SCAN_DIV,
  parameter LOAD_MAX_CYC = `LOAD_MAX_CYC
) (
  input wire ref_clk, // 20 MHz clock
  input wire rst_n, // Synchronous reset, active low
  input wire count_in, // Count input
  input wire up_dn, // High counts up
  input wire reset_cnt_n, // Counter reset, active low
  input wire store_n, // Latch update, active low
  input wire [1:0] counter_preset_ctl, // Three-level code
  input wire [1:0] register_preset_ctl, // Three-level code
  input wire [1:0] view_control, // Three-level code
  input wire [3:0] bcd_in, // BCD port input level
  input wire bcd_in_driven, // Low when switches all open
  output reg [3:0] bcd_out, // BCD port output data
  output reg bcd_oe, // BCD port output enable
  output reg [3:0] digit_strobe, // bit3 msd_strobe, bit0 lsd_strobe
  output reg [3:0] digit_bcd, // Digit value for display
  output reg blank, // Digit blanked
  output reg equal_n, // Counter equals register, active low
  output reg zero_n, // Counter is zero, active low
  output reg carry, // Carry or borrow pulse
  output reg loading, // Preset load in progress
  output reg irq, // Interrupt level
  input wire [31:0] wb_adr_i, // Wishbone address
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire wb_we_i, // Wishbone write
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  output reg wb_ack_o // Wishbone acknowledge
);

  // ****************************************************
  // States
  // ****************************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_LOAD = 2'b10;

  reg [1:0] state;
  reg [15:0] counter;
  reg [15:0] cmp_reg;
  reg [15:0] latch;
  reg [1:0] phase;
  reg [15:0] scan_cnt;
  reg scan_tick;
  reg load_ctr;
  reg load_reg;
  reg cnt_s1;
  reg cnt_s2;
  reg cnt_prev;
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [`EV_WIDTH-1:0] irq_stat;
  reg [`EV_WIDTH-1:0] irq_mask;
  reg [31:0] load_timer;
  reg lz_blank;
  reg [15:0] next_count;
  reg next_carry;
  reg [3:0] preset_digit;
  reg [3:0] cur_digit;
  reg [`EV_WIDTH-1:0] events;
  reg equal_prev;
  reg zero_prev;

  wire count_pulse;
  wire lc_high;
  wire lr_high;
  wire lr_low;
  wire lc_low;
  wire wb_req;
  wire [3:0] wb_ofs;
  wire eq_now;
  wire zero_now;
  integer i;

  // ****************************************************
  // Three-level decode and input conditioning
  // ****************************************************
  assign lc_high = (counter_preset_ctl == `TRI_HIGH);
  assign lc_low = (counter_preset_ctl == `TRI_LOW);
  assign lr_high = (register_preset_ctl == `TRI_HIGH);
  assign lr_low = (register_preset_ctl == `TRI_LOW);

  always @* begin
    // Open switches bias to zero regardless of variant
    if (!bcd_in_driven) begin
      preset_digit = 4'h0;
    end else if (ctrl[`CTRL_CC_VARIANT]) begin
      preset_digit = ~bcd_in;
    end else begin
      preset_digit = bcd_in;
    end
  end

  // Second stage only feeds the edge detector
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_s1 <= 1'b0;
      cnt_s2 <= 1'b0;
      cnt_prev <= 1'b0;
    end else begin
      cnt_s1 <= count_in;
      cnt_s2 <= cnt_s1;
      cnt_prev <= cnt_s2;
    end
  end
  assign count_pulse = cnt_s2 & ~cnt_prev;

  // ****************************************************
  // BCD next-count arithmetic
  // ****************************************************
  always @* begin
    next_count = counter;
    next_carry = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      if (next_carry) begin
        if (up_dn) begin
          if (counter[i*4 +: 4] == 4'h9) begin
            next_count[i*4 +: 4] = 4'h0;
          end else begin
            next_count[i*4 +: 4] = counter[i*4 +: 4] + 4'h1;
            next_carry = 1'b0;
          end
        end else begin
          if (counter[i*4 +: 4] == 4'h0) begin
            next_count[i*4 +: 4] = 4'h9;
          end else begin
            next_count[i*4 +: 4] = counter[i*4 +: 4] - 4'h1;
            next_carry = 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************
  // Scan divider
  // ****************************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      scan_cnt <= 16'h0000;
      scan_tick <= 1'b0;
    end else if ((lr_low || lc_high || lr_high) && state == ST_IDLE) begin
      scan_cnt <= 16'h0000;
      scan_tick <= 1'b0;
    end else if (scan_cnt == SCAN_DIV[15:0] - 16'h0001) begin
      scan_cnt <= 16'h0000;
      scan_tick <= 1'b1;
    end else begin
      scan_cnt <= scan_cnt + 16'h0001;
      scan_tick <= 1'b0;
    end
  end

  // ****************************************************
  // Counter, register, preset sequencer
  // ****************************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      counter <= 16'h0000;
      cmp_reg <= 16'h0000;
      latch <= 16'h0000;
      phase <= 2'h3;
      load_ctr <= 1'b0;
      load_reg <= 1'b0;
      carry <= 1'b0;
      load_timer <= 32'h0000_0000;
    end else begin
      carry <= 1'b0;
      if (!store_n) begin
        latch <= counter;
      end
      case (state)
        ST_IDLE: begin
          load_timer <= 32'h0000_0000;
          if (lc_high || lr_high) begin
            // Both captured in one instant share every digit
            load_ctr <= lc_high;
            load_reg <= lr_high;
            phase <= 2'h3;
            state <= ST_LOAD;
          end else if (lr_low) begin
            phase <= 2'h3;
          end else if (scan_tick) begin
            phase <= phase - 2'h1;
          end
          if (!reset_cnt_n) begin
            counter <= 16'h0000;
          end else if (count_pulse && !lc_high) begin
            counter <= next_count;
            carry <= next_carry;
          end
        end
        ST_LOAD: begin
          load_timer <= load_timer + 32'h0000_0001;
          // Counts during load are dropped; reload costs four digit periods
          if (!reset_cnt_n) begin
            counter <= 16'h0000;
          end
          if (scan_tick || load_timer >= LOAD_MAX_CYC) begin
            if (load_ctr) begin
              counter[phase*4 +: 4] <= reset_cnt_n ? preset_digit : 4'h0;
            end
            if (load_reg) begin
              cmp_reg[phase*4 +: 4] <= reset_cnt_n ? preset_digit : 4'h0;
            end
            if (phase == 2'h0) begin
              phase <= 2'h3;
              load_timer <= 32'h0000_0000;
              if (lc_high || lr_high) begin
                load_ctr <= lc_high;
                load_reg <= lr_high;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              phase <= phase - 2'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // Compare and outputs
  // ****************************************************
  assign eq_now = (counter == cmp_reg);
  assign zero_now = (counter == 16'h0000);

  always @* begin
    cur_digit = latch[phase*4 +: 4];
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      equal_n <= 1'b1;
      zero_n <= 1'b1;
      loading <= 1'b0;
      bcd_out <= 4'h0;
      bcd_oe <= 1'b0;
      digit_strobe <= 4'h0;
      digit_bcd <= 4'h0;
      blank <= 1'b1;
      lz_blank <= 1'b1;
    end else begin
      // Flags track raw compare; loading marks them untrustworthy
      equal_n <= ~eq_now;
      zero_n <= ~zero_now;
      loading <= (state == ST_LOAD);
      bcd_out <= cur_digit;
      bcd_oe <= (state == ST_IDLE) && !lc_low && !lr_low;
      digit_strobe <= lr_low ? 4'h0 : (4'h1 << phase);
      digit_bcd <= cur_digit;
      if (phase == 2'h3) begin
        lz_blank <= (cur_digit == 4'h0);
      end else if (cur_digit != 4'h0) begin
        lz_blank <= 1'b0;
      end
      blank <= lr_low || (view_control == `TRI_HIGH) ||
        ((view_control == `TRI_OPEN) && phase != 2'h0 && cur_digit == 4'h0 &&
        (phase == 2'h3 || lz_blank));
    end
  end

  // ****************************************************
  // Wishbone slave and interrupts
  // ****************************************************
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_ofs = wb_adr_i[3:0];

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      equal_prev <= 1'b0;
      zero_prev <= 1'b0;
    end else begin
      equal_prev <= eq_now;
      zero_prev <= zero_now;
    end
  end

  always @* begin
    events = {`EV_WIDTH{1'b0}};
    events[`EV_EQUAL] = eq_now & ~equal_prev & (state == ST_IDLE);
    events[`EV_ZERO] = zero_now & ~zero_prev & (state == ST_IDLE);
    events[`EV_LOAD_DONE] = (state == ST_LOAD) & loading & ~(lc_high | lr_high) &
      (scan_tick | (load_timer >= LOAD_MAX_CYC)) & (phase == 2'h0);
    events[`EV_CARRY] = carry;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= `CTRL_RESET_VAL;
      irq_stat <= {`EV_WIDTH{1'b0}};
      irq_mask <= {`EV_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      // Read clears, but a new event in that cycle survives
      if (wb_req && !wb_we_i && wb_adr_i[4] && wb_ofs == `OFS_IRQ_STAT) begin
        irq_stat <= events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        if (!wb_adr_i[4] && wb_ofs == `OFS_CTRL) begin
          ctrl <= wb_dat_i[`CTRL_WIDTH-1:0];
        end
        if (wb_adr_i[4] && wb_ofs == `OFS_IRQ_MASK) begin
          irq_mask <= wb_dat_i[`EV_WIDTH-1:0];
        end
      end
      if (wb_req && !wb_we_i) begin
        case ({wb_adr_i[4], wb_ofs})
          {1'b0, `OFS_CTRL}: wb_dat_o <= {30'h0, ctrl};
          {1'b0, `OFS_STATUS}: wb_dat_o <= {28'h0, loading, ~zero_n, ~equal_n,
            state == ST_LOAD};
          {1'b0, `OFS_COUNT}: wb_dat_o <= {16'h0000, counter};
          {1'b0, `OFS_REG}: wb_dat_o <= {16'h0000, cmp_reg};
          {1'b1, `OFS_IRQ_STAT}: wb_dat_o <= {28'h0, irq_stat};
          {1'b1, `OFS_IRQ_MASK}: wb_dat_o <= {28'h0, irq_mask};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule
`default_nettype wire

// [testbench/bcd_counter_chk.sv]
// Purpose: port checker for the BCD counter with compare
// Assumes: one ref_clk domain, rst_n synchronous
// Notes: bound to the design top after the module
`timescale 1ns/10ps
`default_nettype none
`include "updown_counter_regs.vh"
module bcd_counter_chk #(
  parameter SCAN_DIV = 8,
  parameter LOAD_MAX_CYC = 40
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic reset_cnt_n, // Counter clear
  input wire logic [1:0] counter_preset_ctl, // Counter preset code
  input wire logic [1:0] register_preset_ctl, // Register preset code
  input wire logic bcd_oe, // Port drive enable
  input wire logic [3:0] digit_strobe, // Scan phase
  input wire logic zero_n, // Zero flag
  input wire logic carry, // Wrap pulse
  input wire logic loading, // Load busy
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o // Bus acknowledge
);
  // ****************************************************
  // Properties
  // ****************************************************
  int rel_cnt;
  // Counts load cycles after both preset controls let go
  always @(posedge ref_clk)
    if (!rst_n || !loading || counter_preset_ctl == `TRI_HIGH || register_preset_ctl == `TRI_HIGH)
      rel_cnt <= 0;
    else
      rel_cnt <= rel_cnt + 1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence load_start; $rose(loading); endsequence
  sequence wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  a_load_msd: assert property (load_start |-> ##[0:3] digit_strobe == 4'h8)
    else $error("load scan did not start at top digit");
  a_load_bound: assert property (rel_cnt <= LOAD_MAX_CYC)
    else $error("load ran too long after release");
  a_one_strobe: assert property ($onehot0(digit_strobe))
    else $error("more than one digit strobe");
  a_ack_next: assert property (wb_req |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_carry_pulse: assert property (carry |=> !carry)
    else $error("carry longer than one cycle");
  a_load_hiz: assert property (loading |-> !bcd_oe)
    else $error("port driven during load");
  a_oe_off: assert property ((counter_preset_ctl == `TRI_LOW)[*3] |-> !bcd_oe)
    else $error("port driven with preset held low");
  a_scan_off: assert property ((register_preset_ctl == `TRI_LOW)[*3] |-> digit_strobe == 4'h0)
    else $error("scan running with display off");
  a_reset_zero: assert property ((!reset_cnt_n && !loading)[*4] |-> !zero_n)
    else $error("counter clear not seen on zero flag");
endmodule
bind bcd_updown_counter_compare bcd_counter_chk #(.SCAN_DIV(SCAN_DIV), .LOAD_MAX_CYC(LOAD_MAX_CYC)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reset_cnt_n(reset_cnt_n),
  .counter_preset_ctl(counter_preset_ctl), .register_preset_ctl(register_preset_ctl),
  .bcd_oe(bcd_oe), .digit_strobe(digit_strobe), .zero_n(zero_n), .carry(carry),
  .loading(loading), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [testbench/bcd_switch_bank.sv]
// Purpose: thumbwheel switch bank on the BCD port
// Assumes: one switch digit selected per digit strobe
// Notes: open switches fall to the bias level
`timescale 1ns/10ps
`default_nettype none
module bcd_switch_bank (
  input wire logic [3:0] digit_strobe, // Active digit
  input wire logic [15:0] sw_value, // Switch settings
  input wire logic low_true, // Common-cathode wiring
  input wire logic all_open, // Every switch open
  output logic [3:0] bcd_in, // Port level
  output logic bcd_in_driven // A switch is closed
);
  // ****************************************************
  // Switch levels
  // ****************************************************
  logic [3:0] digit;
  always_comb begin
    case (digit_strobe)
      4'h8: digit = sw_value[15:12];
      4'h4: digit = sw_value[11:8];
      4'h2: digit = sw_value[7:4];
      4'h1: digit = sw_value[3:0];
      default: digit = 4'h0;
    endcase
    // Unselected or open lines sit at the bias level, never the last value
    bcd_in_driven = !all_open && digit_strobe != 4'h0;
    if (!bcd_in_driven)
      digit = 4'h0;
    bcd_in = low_true ? ~digit : digit;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the BCD counter with compare
// Assumes: shortened scan and load counts
// Notes: integer model of counter and register
`timescale 1ns/10ps
`default_nettype none
`include "updown_counter_regs.vh"
module tb_top;
  // ****************************************************
  // Signals
  // ****************************************************
  logic ref_clk = 0, rst_n = 0, count_in = 0, up_dn = 1, reset_cnt_n = 1, store_n = 0;
  logic [1:0] lc = `TRI_OPEN, lr = `TRI_OPEN, view = `TRI_OPEN;
  logic [31:0] adr = 0, wdat = 0, rdat;
  logic we = 0, cyc = 0, stb = 0, low_true = 0, all_open = 0;
  logic [15:0] sw = 0;
  wire [3:0] bcd_in, bcd_out, strobe, digit_bcd;
  wire bcd_in_driven, bcd_oe, blank, equal_n, zero_n, carry, loading, irq, ack;
  wire [31:0] dat_o;
  int failures = 0, n_tests = 0, cnt_m = 0, reg_m = 0, v, i, n_carry = 0;
  bcd_updown_counter_compare #(.SCAN_DIV(8), .LOAD_MAX_CYC(40)) u_bcd_updown_counter_compare (
    .ref_clk(ref_clk), .rst_n(rst_n), .count_in(count_in), .up_dn(up_dn),
    .reset_cnt_n(reset_cnt_n), .store_n(store_n), .counter_preset_ctl(lc),
    .register_preset_ctl(lr), .view_control(view), .bcd_in(bcd_in),
    .bcd_in_driven(bcd_in_driven), .bcd_out(bcd_out), .bcd_oe(bcd_oe),
    .digit_strobe(strobe), .digit_bcd(digit_bcd), .blank(blank), .equal_n(equal_n),
    .zero_n(zero_n), .carry(carry), .loading(loading), .irq(irq), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack));
  bcd_switch_bank u_bcd_switch_bank (.digit_strobe(strobe), .sw_value(sw),
    .low_true(low_true), .all_open(all_open), .bcd_in(bcd_in), .bcd_in_driven(bcd_in_driven));
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (carry === 1'b1) n_carry <= n_carry + 1;
  // ****************************************************
  // Tasks
  // ****************************************************
  function automatic logic [15:0] to_bcd(input int n);
    to_bcd = {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk) begin adr <= a; we <= w; wdat <= d; cyc <= 1; stb <= 1; end
    n = 0;
    do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50) failures++;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task pulse(input logic up);
    @(posedge ref_clk) up_dn <= up;
    repeat (2) @(posedge ref_clk);
    count_in <= 1;
    repeat (3) @(posedge ref_clk);
    count_in <= 0;
    repeat (4) @(posedge ref_clk);
    cnt_m = up ? (cnt_m + 1) % 10000 : (cnt_m + 9999) % 10000;
  endtask
  task load(input logic c, input logic r, input int val);
    int n;
    // Spacing from any earlier load or clear
    repeat (45) @(posedge ref_clk);
    sw <= to_bcd(val);
    lc <= c ? `TRI_HIGH : `TRI_OPEN;
    lr <= r ? `TRI_HIGH : `TRI_OPEN;
    repeat (3) @(posedge ref_clk);
    lc <= `TRI_OPEN;
    lr <= `TRI_OPEN;
    n = 0;
    while (loading !== 1'b1 && n < 30) begin @(posedge ref_clk); n++; end
    n = 0;
    while (loading !== 1'b0 && n < 300) begin @(posedge ref_clk); n++; end
    if (n >= 300) failures++;
    if (c) cnt_m = all_open ? 0 : val;
    if (r) reg_m = all_open ? 0 : val;
    repeat (2) @(posedge ref_clk);
  endtask
  task rnd;
    v = $urandom % 10000;
  endtask
  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    void'($urandom(32'hd2c03928));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    bus(32'h0, 0, 0); chk(rdat, 32'h0);
    bus(32'h8, 0, 0); chk(rdat, 32'h0);
    bus(32'h18, 1, 32'hFF); bus(32'h18, 0, 0); chk(rdat, 32'h0);
    for (i = 0; i < 3; i++) begin
      view <= 2'(i);
      rnd; load(1, 0, v);
      bus(32'h8, 0, 0); chk(rdat, to_bcd(cnt_m));
      while (strobe !== 4'h8) @(posedge ref_clk);
      chk(digit_bcd, to_bcd(cnt_m) >> 12);
      chk(bcd_out, to_bcd(cnt_m) >> 12);
      chk(blank, i == 1 || (i == 0 && to_bcd(cnt_m) < 16'h1000));
    end
    rnd; load(0, 1, v);
    bus(32'hC, 0, 0); chk(rdat, to_bcd(reg_m));
    bus(32'h8, 0, 0); chk(rdat, to_bcd(cnt_m));
    rnd; load(1, 1, 5 + v % 9985);
    bus(32'h8, 0, 0); chk(rdat, to_bcd(cnt_m));
    bus(32'hC, 0, 0); chk(rdat, to_bcd(reg_m));
    chk(equal_n, 1'b0);
    // Divider style: equality fed back to the clear after a delay
    repeat (45) @(posedge ref_clk);
    reset_cnt_n <= 0;
    @(posedge ref_clk) reset_cnt_n <= 1;
    cnt_m = 0;
    for (i = 0; i < 1 + $urandom % 4; i++) pulse(1);
    bus(32'h8, 0, 0); chk(rdat, to_bcd(cnt_m));
    chk(equal_n, 1'b1);
    @(posedge ref_clk) reset_cnt_n <= 0;
    repeat (6) @(posedge ref_clk);
    reset_cnt_n <= 1;
    cnt_m = 0;
    bus(32'h8, 0, 0); chk(rdat, 32'h0);
    bus(32'hC, 0, 0); chk(rdat, to_bcd(reg_m));
    v = n_carry;
    pulse(0);
    bus(32'h8, 0, 0); chk(rdat, to_bcd(cnt_m));
    chk(n_carry - v, 32'h1);
    bus(32'h0, 1, 1); low_true <= 1;
    rnd; load(1, 0, v);
    bus(32'h8, 0, 0); chk(rdat, to_bcd(cnt_m));
    bus(32'h0, 1, 0); low_true <= 0;
    all_open <= 1;
    rnd; load(1, 0, v);
    bus(32'h8, 0, 0); chk(rdat, 32'h0);
    chk(zero_n, 1'b0);
    all_open <= 0;
    lc <= `TRI_LOW; lr <= `TRI_LOW;
    repeat (5) @(posedge ref_clk);
    chk(bcd_oe, 1'b0);
    lc <= `TRI_OPEN; lr <= `TRI_OPEN;
    repeat (12) @(posedge ref_clk);
    chk(bcd_oe, 1'b1);
    bus(32'h14, 1, 32'h4); bus(32'h14, 0, 0); chk(rdat, 32'h4);
    bus(32'h10, 0, 0);
    rnd; load(0, 1, v);
    chk(irq, 1'b1);
    bus(32'h10, 0, 0); chk(rdat[2], 1'b1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    bus(32'h14, 1, 0);
    rnd; load(0, 1, v);
    chk(irq, 1'b0);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
